/* rpcf_pkg.sv */
// Shared types and constants of the receive phase compensation FIFO
package rpcf_pkg;

	localparam int DATA_W = 16;
	localparam int STAT_W = 4;
	localparam int FIFO_AW = 3;
	localparam logic [FIFO_AW:0] START_LVL = 4'h2;
	localparam logic [FIFO_AW:0] CNT_RST = 4'h0;
	localparam logic TOG_RST = 1'b0;
	localparam logic FLAG_RST = 1'b0;

	// Write clock source of the channel
	typedef enum logic [1:0] {
		RPCF_NB_RM,
		RPCF_NB_NORM,
		RPCF_BOND_X4,
		RPCF_BOND_X8
	} rpcf_wsrc_t;

	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic [STAT_W-1:0] status;
	} rpcf_word_t;

	localparam rpcf_word_t WORD_RST = '0;

endpackage

/* rpcf_fifo.sv */
// Storage and pointers of the phase compensation FIFO
`timescale 1ns/1ps
module rpcf_fifo #(
	parameter int AW = rpcf_pkg::FIFO_AW
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// Write side
	input wire logic i_push,
	input wire rpcf_pkg::rpcf_word_t i_wdata,
	// Read side
	input wire logic i_pop,
	output rpcf_pkg::rpcf_word_t o_rdata,
	// Status
	output logic [AW:0] o_count,
	output logic o_full,
	output logic o_empty
);
	import rpcf_pkg::*;

	rpcf_word_t mem [2**AW];
	logic [AW:0] wptr_q;
	logic [AW:0] rptr_q;

	assign o_count = wptr_q - rptr_q;
	assign o_full = (o_count == (AW+1)'(2**AW));
	assign o_empty = (wptr_q == rptr_q);
	assign o_rdata = mem[rptr_q[AW-1:0]];

	always_ff @(posedge i_ref_clk) begin
		if (i_push) begin
			mem[wptr_q[AW-1:0]] <= i_wdata;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wptr_q <= '0;
			rptr_q <= '0;
		end else begin
			if (i_push) begin
				wptr_q <= wptr_q + 1'b1;
			end
			if (i_pop) begin
				rptr_q <= rptr_q + 1'b1;
			end
		end
	end

endmodule // rpcf_fifo

/* rpcf_rx_fifo_top.sv */
// Receive phase compensation FIFO with selectable write and read clocks
// Overview of operation
// - With the user read port enabled, its enable pulse times every read.
// - Any rate mismatch overflows or underruns the FIFO; flags report it.
// - Non-bonded with rate matcher writes on the transmit parallel clock.
// - Non-bonded without rate matcher writes on recovered parallel clock.
// - Four-lane bonded writes on the local bonded core clock.
// - Eight-lane bonded writes on the master block's bonded core clock.
// - Byte deserializer halves the selected write clock.
// - Without the user port the read clock follows the write clock.
`timescale 1ns/1ps
module rpcf_rx_fifo_top #(
	parameter int AW = rpcf_pkg::FIFO_AW
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// Configuration
	input wire rpcf_pkg::rpcf_wsrc_t i_wsrc,
	input wire logic i_byte_deser,
	input wire logic i_user_rd_port,
	// Write clock enables from the transceiver side
	input wire logic i_tx_par_en,
	input wire logic i_rx_rec_en,
	input wire logic i_core_en,
	input wire logic i_master_core_en,
	// Receive word from the PCS
	input wire rpcf_pkg::rpcf_word_t i_rx_word,
	// User read clock enable
	input wire logic i_user_rd_en,
	// Error flag clear
	input wire logic i_err_clr,
	// Fabric side
	output rpcf_pkg::rpcf_word_t o_rx_word,
	output logic o_rx_valid,
	output logic o_overflow,
	output logic o_underrun,
	output logic [AW:0] o_fill
);
	import rpcf_pkg::*;

	logic wr_base_en;
	logic wr_en;
	logic rd_clk_en;
	logic push;
	logic pop;
	logic ovf_evt;
	logic unr_evt;
	logic full;
	logic empty;
	logic [AW:0] count;
	rpcf_word_t rdata;
	logic tog_q;
	logic tog_d;
	logic started_q;
	rpcf_word_t word_q;
	logic valid_q;
	logic ovf_q;
	logic ovf_d;
	logic unr_q;
	logic unr_d;
	logic [AW:0] fill_q;

	////////////////////////////////////////////////////////////////////////
	// Write clock selection
	assign wr_base_en = (i_wsrc == RPCF_NB_RM) ? i_tx_par_en :
		(i_wsrc == RPCF_NB_NORM) ? i_rx_rec_en :
		(i_wsrc == RPCF_BOND_X4) ? i_core_en :
		i_master_core_en;
	assign tog_d = wr_base_en ? ~tog_q : tog_q;
	assign wr_en = i_byte_deser ? (wr_base_en & tog_q) : wr_base_en;

	////////////////////////////////////////////////////////////////////////
	// Read clock selection and FIFO control
	assign rd_clk_en = i_user_rd_port ? i_user_rd_en : wr_en;
	assign push = wr_en & ~full;
	assign pop = rd_clk_en & started_q & ~empty;
	assign ovf_evt = wr_en & full;
	assign unr_evt = rd_clk_en & started_q & empty;
	// Set wins over clear
	assign ovf_d = ovf_evt | (ovf_q & ~i_err_clr);
	assign unr_d = unr_evt | (unr_q & ~i_err_clr);

	rpcf_fifo #(
		.AW(AW)
	) u_fifo (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_push(push),
		.i_wdata(i_rx_word),
		.i_pop(pop),
		.o_rdata(rdata),
		.o_count(count),
		.o_full(full),
		.o_empty(empty)
	);

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tog_q <= TOG_RST;
			started_q <= FLAG_RST;
		end else begin
			tog_q <= tog_d;
			// Hold reads off until the FIFO is primed
			if (count >= START_LVL) begin
				started_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registered outputs
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			word_q <= WORD_RST;
			valid_q <= FLAG_RST;
			ovf_q <= FLAG_RST;
			unr_q <= FLAG_RST;
			fill_q <= CNT_RST;
		end else begin
			if (pop) begin
				word_q <= rdata;
			end
			valid_q <= pop;
			ovf_q <= ovf_d;
			unr_q <= unr_d;
			fill_q <= count;
		end
	end

	assign o_rx_word = word_q;
	assign o_rx_valid = valid_q;
	assign o_overflow = ovf_q;
	assign o_underrun = unr_q;
	assign o_fill = fill_q;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_n);

	// Read clock choice
	a_user_rd_clk: assert property (
		i_user_rd_port && !i_user_rd_en |=> !o_rx_valid)
		else $error("read happened without user read enable");
	a_auto_rd_clk: assert property (
		!i_user_rd_port && started_q && !empty && wr_en |=> o_rx_valid)
		else $error("auto read clock did not read");
	a_auto_no_read: assert property (
		!i_user_rd_port && !wr_en |=> !o_rx_valid)
		else $error("auto read clock read without write enable");

	// Error flags
	a_ovf_flag: assert property (
		wr_en && full |=> o_overflow ##1
		(o_overflow || $past(i_err_clr)))
		else $error("overflow not flagged");
	a_unr_flag: assert property (
		rd_clk_en && started_q && empty |=> o_underrun && !o_rx_valid)
		else $error("underrun not flagged");
	a_ovf_sticky: assert property (
		o_overflow && !i_err_clr |=> o_overflow)
		else $error("overflow flag lost without clear");
	a_unr_sticky: assert property (
		o_underrun && !i_err_clr |=> o_underrun)
		else $error("underrun flag lost without clear");
	a_ovf_clear: assert property (
		o_overflow && i_err_clr && !ovf_evt |=> !o_overflow)
		else $error("overflow flag not cleared");
	a_unr_clear: assert property (
		o_underrun && i_err_clr && !unr_evt |=> !o_underrun)
		else $error("underrun flag not cleared");

	// Write clock choice
	a_wr_tx_par: assert property (
		i_wsrc == RPCF_NB_RM && !i_byte_deser
		|-> push == (i_tx_par_en && !full))
		else $error("write not on transmit parallel clock");
	a_wr_rx_rec: assert property (
		i_wsrc == RPCF_NB_NORM && !i_byte_deser
		|-> push == (i_rx_rec_en && !full))
		else $error("write not on recovered clock");
	a_wr_core_x4: assert property (
		i_wsrc == RPCF_BOND_X4 && !i_byte_deser
		|-> push == (i_core_en && !full))
		else $error("write not on local core clock");
	a_wr_core_x8: assert property (
		i_wsrc == RPCF_BOND_X8 && !i_byte_deser
		|-> push == (i_master_core_en && !full))
		else $error("write not on master core clock");
	a_deser_half: assert property (
		i_byte_deser && $stable(i_byte_deser) && wr_en |-> !$past(wr_en))
		else $error("write rate not halved");

	// Ordering and fill
	a_word_order: assert property (
		pop |=> o_rx_word == $past(rdata) && o_fill == $past(count))
		else $error("read word out of order");
	a_word_hold: assert property (
		!pop |=> $stable(o_rx_word))
		else $error("read word changed without a read");
	a_valid_pop: assert property (
		!pop |=> !o_rx_valid)
		else $error("valid raised without a read");
	a_fill_bound: assert property (
		o_fill <= (AW+1)'(2**AW))
		else $error("fill beyond FIFO depth");
	a_fill_step: assert property (
		o_fill <= $past(o_fill) + 1)
		else $error("fill rose by more than one word");

	c_overflow: cover property (ovf_evt);
	c_underrun: cover property (unr_evt);
	c_user_read: cover property (i_user_rd_port && pop ##1 o_rx_valid);
	c_deser_push: cover property (i_byte_deser && push);
	c_auto_read: cover property (!i_user_rd_port && pop);

endmodule // rpcf_rx_fifo_top

/* rpcf_fabric_model.sv */
// Fabric receive capture logic on the shared read clock
`timescale 1ns/1ps
module rpcf_fabric_model (
	// Common clock driver
	input wire logic i_ref_clk,
	// Bench request and FIFO outputs
	input wire logic i_rd_go,
	input wire rpcf_pkg::rpcf_word_t i_rx_word,
	input wire logic i_rx_valid,
	// Read enable and captured word
	output logic o_rd_en,
	output rpcf_pkg::rpcf_word_t o_cap_word,
	output logic o_cap_stb
);
	import rpcf_pkg::*;
	initial o_rd_en = 1'b0;
	initial o_cap_stb = 1'b0;
	initial o_cap_word = WORD_RST;
	// Read timing from the ungated common driver, half a cycle offset on the falling edge
	always @(negedge i_ref_clk) o_rd_en <= i_rd_go;
	// Capture on the same driver that times the read
	always @(posedge i_ref_clk) begin
		o_cap_stb <= i_rx_valid;
		o_cap_word <= i_rx_word;
	end
endmodule // rpcf_fabric_model

/* rpcf_rx_fifo_top_tb_top.sv */
// Self-checking bench of the receive phase compensation FIFO
`timescale 1ns/1ps
module rpcf_rx_fifo_top_tb_top;
	import rpcf_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	rpcf_wsrc_t wsrc = RPCF_NB_RM;
	logic deser = 1'b0;
	logic uport = 1'b0;
	logic [3:0] en = 4'h0;
	rpcf_word_t word = WORD_RST;
	logic rd_go = 1'b0;
	logic clr = 1'b0;
	rpcf_word_t rx_word, cap_word;
	logic rx_valid, ovf, unr, cap_stb, rd_en;
	logic [FIFO_AW:0] fill;
	logic [31:0] seed = 32'hd4bd_08a5;
	int mismatches = 0;
	int samples_checked = 0;
	int tog = 0;
	rpcf_word_t expq[$];
	always #2 clk = ~clk;
	rpcf_rx_fifo_top dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_wsrc(wsrc),
		.i_byte_deser(deser), .i_user_rd_port(uport), .i_tx_par_en(en[0]),
		.i_rx_rec_en(en[1]), .i_core_en(en[2]), .i_master_core_en(en[3]),
		.i_rx_word(word), .i_user_rd_en(rd_en), .i_err_clr(clr),
		.o_rx_word(rx_word), .o_rx_valid(rx_valid), .o_overflow(ovf),
		.o_underrun(unr), .o_fill(fill));
	rpcf_fabric_model fab (.i_ref_clk(clk), .i_rd_go(rd_go),
		.i_rx_word(rx_word), .i_rx_valid(rx_valid), .o_rd_en(rd_en),
		.o_cap_word(cap_word), .o_cap_stb(cap_stb));
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// One cycle of stimulus plus the reference write model
	task automatic step(input logic [3:0] e, input logic go);
		logic w;
		@(negedge clk);
		seed = lfsr(seed);
		en <= e;
		word <= seed[19:0];
		rd_go <= go;
		w = e[wsrc];
		if (w && deser) begin
			tog ^= 1;
			w = (tog == 0);
		end
		if (w && expq.size() < 8) expq.push_back(seed[19:0]);
	endtask
	task automatic do_reset();
		@(negedge clk);
		rst_n <= 1'b0;
		en <= 4'h0;
		rd_go <= 1'b0;
		repeat (5) @(negedge clk);
		chk({rx_word, rx_valid, ovf, unr, fill}, 32'h0);
		rst_n <= 1'b1;
		tog = 0;
		expq.delete();
	endtask
	always @(negedge clk) begin
		if (cap_stb === 1'b1) begin
			if (expq.size() == 0) chk(32'h1, 32'h0);
			else chk(cap_word, expq.pop_front());
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		int c, i;
		for (c = 0; c < 8; c++) begin
			do_reset();
			wsrc = rpcf_wsrc_t'(c[1:0]);
			deser = c[2];
			for (i = 0; i < 80; i++) step(seed[27:24], 1'b0);
			chk({ovf, unr}, 2'b00);
		end
		do_reset();
		wsrc = RPCF_NB_RM;
		deser = 1'b0;
		uport = 1'b1;
		for (i = 0; i < 9; i++) step(4'h1, 1'b0);
		repeat (2) step(4'h0, 1'b0);
		chk({ovf, unr, fill}, {1'b1, 1'b0, 4'h8});
		for (i = 0; i < 10; i++) step(4'h0, 1'b1);
		repeat (3) step(4'h0, 1'b0);
		chk(expq.size(), 32'h0);
		chk({ovf, unr, fill}, {1'b1, 1'b1, 4'h0});
		clr = 1'b1;
		step(4'h0, 1'b0);
		clr = 1'b0;
		repeat (2) step(4'h0, 1'b0);
		chk({ovf, unr}, 2'b00);
		wrap_up();
	end
endmodule // rpcf_rx_fifo_top_tb_top
